//--- rtl/pmo_core.sv
// Memory-reference ordering, write buffer, I/O handling and branch prediction
// Operation
// RULE1 - Mid-string exception keeps instruction restartable
// RULE2 - Clear trace-pending, push same instruction address
// RULE3 - Four stages, two-entry write buffer
// RULE4 - Fetch and reads finish before writes
// RULE5 - Fetch after earlier fetches complete
// RULE6 - Reads in order, bypass only independent
// RULE7 - Hold read overlapping pending write
// RULE8 - Interlocked op after drain, before reads
// RULE9 - Writes leave in program order
// RULE10 - Prefetches not checked against pending writes
// RULE11 - Speculative accesses may set referenced bit
// RULE12 - Backward taken, forward not, le/ne taken
// RULE13 - Loader predicts, saves alternate stream
// RULE14 - Inhibit on speculative or write-pending reads
// RULE15 - External decode flags sensitive peripherals
// RULE16 - Decode under inhibit: discard, serialize, retry
// RULE17 - Region reads wait for region writes
// RULE18 - Cross-region bypass allowed
// RULE19 - Serialize drains writes before next fetch
// RULE20 - Listed instructions request serialization
// RULE21 - Status word load flushes and refetches
// RULE22 - Reset or fatal error discards pending writes
// RULE23 - Full buffer stalls result producer
`timescale 1ns/1ns
`default_nettype none
`include "pmo_regs.svh"
// One write-buffer entry compared against the read waiting for the bus
module pmo_wb_cmp
    import pmo_pkg::*;
(
    input wire logic vld_i, // Entry holds an unwritten result
    input wire pmo_pkg::pmo_ref_s ent_i, // Buffered result address and length
    input wire pmo_pkg::pmo_ref_s rd_i, // Source read address and length
    output logic dep_o, // Read overlaps this entry
    output logic io_o // Entry is a write into the I/O region
);
    import pmo_pkg::*;

    logic [32:0] ent_end;
    logic [32:0] rd_end;

    // One bit wider, so a reference at the top of memory cannot wrap to zero
    assign ent_end = {1'b0, ent_i.addr} + {30'h0, ent_i.len};
    assign rd_end = {1'b0, rd_i.addr} + {30'h0, rd_i.len};
    assign dep_o = vld_i && ({1'b0, rd_i.addr} < ent_end)
                   && ({1'b0, ent_i.addr} < rd_end); // see RULE7
    assign io_o = vld_i && (ent_i.addr >= `PMO_IO_BASE); // see RULE17
endmodule

module pmo_core
    import pmo_pkg::*;
#(
    parameter int WB_DEPTH = `PMO_WB_DEPTH
) (
    input wire logic clk_i,                      // 20 MHz clock
    input wire logic sys_rst_i,                  // Async reset, active high
    // Fetch side
    input wire logic fetch_req_i,                // Fetch of next instruction wanted
    input wire logic prev_fetch_done_i,          // Earlier instructions fully fetched
    output logic fetch_go_o,                     // Fetch may start
    // Branch loader
    input wire logic br_valid_i,                 // Conditional branch decoded
    input wire pmo_pkg::pmo_branch_s br_i,       // Branch pc, displacement, kind
    input wire logic br_resolve_i,               // Execution unit resolves branch
    input wire logic br_taken_i,                 // Actual decision
    output logic br_pred_taken_o,                // Prediction, registered
    output logic [31:0] br_next_o,               // Predicted stream address
    output logic [31:0] br_alt_o,                // Saved alternate stream
    output logic br_mispredict_o,                // Redirect to alternate stream
    // Source reads
    input wire logic rd_req_i,                   // Source read wanted
    input wire pmo_pkg::pmo_ref_s rd_ref_i,      // Physical address and length
    input wire logic rd_spec_i,                  // Read belongs to unexecuted instr
    input wire logic rd_prior_done_i,            // Earlier fetches and reads done
    input wire logic instr_fetched_i,            // This instruction fully fetched
    input wire logic rd_interlocked_i,           // Locked bit set/clear access
    output logic rd_go_o,                        // Read bus cycle may start
    output logic io_inhibit_o,                   // Inhibit for this read cycle
    input wire logic rd_done_i,                  // Bus read cycle ended
    input wire logic io_decode_i,                // Peripheral is order-sensitive
    output logic rd_discard_o,                   // Drop read data and retry
    // Results
    input wire logic wr_req_i,                   // Result ready for buffer
    input wire pmo_pkg::pmo_ref_s wr_ref_i,      // Result address and length
    input wire logic [31:0] wr_data_i,           // Result data
    input wire logic instr_reads_done_i,         // Its fetch and reads completed
    output logic wr_ready_o,                     // Buffer accepts result
    output logic bus_wr_valid_o,                 // Buffered write to bus
    output logic [31:0] bus_wr_addr_o,           // Oldest write address
    output logic [31:0] bus_wr_data_o,           // Oldest write data
    output logic [2:0] bus_wr_len_o,             // Oldest write length
    input wire logic bus_wr_done_i,              // Bus finished the write
    // Serialization and exceptions
    input wire logic ser_instr_i,                // Serializing instruction executed
    input wire logic psr_word_load_i,            // Status word load
    input wire logic exc_taken_i,                // Exception processed
    input wire logic fatal_err_i,                // Nonrestartable bus error
    input wire logic str_abort_i,                // Restartable event mid-string
    input wire logic [31:0] str_pc_i,            // Address of string instruction
    output logic flush_o,                        // Flush pipeline and refetch
    output logic serializing_o,                  // Drain in progress
    output logic trace_clr_o,                    // Clear trace-pending before push
    output logic [31:0] saved_pc_o,              // Pc to push on the stack
    output logic saved_pc_valid_o                // Saved pc is valid
);
    import pmo_pkg::*;

    // Pointer and count widths below serve one to eight entries
    if (WB_DEPTH < 1 || WB_DEPTH > `PMO_WB_MAX) begin : g_bad_depth
        $error("WB_DEPTH out of range");
    end

    // A single entry still needs a one-bit pointer
    localparam int PW = (WB_DEPTH > 1) ? $clog2(WB_DEPTH) : 1;

    logic [WB_DEPTH-1:0] vld_ff;
    pmo_ref_s ref_ff [WB_DEPTH];
    logic [31:0] dat_ff [WB_DEPTH];
    logic [PW-1:0] head_ff;
    logic [PW-1:0] tail_ff;
    logic [PW:0] cnt_ff;
    logic ser_ff;
    logic retry_ff;
    logic inh_ff;

    function automatic logic in_io(input logic [31:0] a);
        return a >= `PMO_IO_BASE;
    endfunction

    // One comparator per entry; any hit holds the read
    logic [WB_DEPTH-1:0] dep_vec;
    logic [WB_DEPTH-1:0] io_vec;
    for (genvar gi = 0; gi < WB_DEPTH; gi++) begin : g_cmp
        pmo_wb_cmp cmp_u (
            .vld_i(vld_ff[gi]),
            .ent_i(ref_ff[gi]),
            .rd_i(rd_ref_i),
            .dep_o(dep_vec[gi]),
            .io_o(io_vec[gi])
        );
    end
    logic dep_hit;
    logic io_wr_pend;
    assign dep_hit = |dep_vec; // see RULE7
    assign io_wr_pend = |io_vec;

    // Count is one bit wider than the pointers, so full differs from empty
    logic wb_empty;
    logic wb_full;
    logic push;
    logic pop;
    assign wb_empty = (cnt_ff == '0);
    assign wb_full = (cnt_ff == (PW+1)'(WB_DEPTH)); // see RULE3
    // Results only after own fetch and reads are done; stall when full
    assign wr_ready_o = !wb_full && instr_reads_done_i && !fatal_err_i; // see RULE4 see RULE23
    assign push = wr_req_i && wr_ready_o;
    assign pop = bus_wr_valid_o && bus_wr_done_i;

    // Oldest entry only reaches the bus, so stores keep program order
    assign bus_wr_valid_o = vld_ff[head_ff]; // see RULE9
    assign bus_wr_addr_o = ref_ff[head_ff].addr;
    assign bus_wr_len_o = ref_ff[head_ff].len;
    assign bus_wr_data_o = dat_ff[head_ff];

    // Region reads wait on region writes only; other reads bypass freely
    logic io_block;
    assign io_block = in_io(rd_ref_i.addr) && io_wr_pend; // see RULE17 see RULE18
    // Interlocked access waits for a fully drained buffer
    logic lock_block;
    assign lock_block = rd_interlocked_i && !wb_empty; // see RULE8
    // Later reads need earlier reads done, this includes the locked access
    // Every buffer, lock and drain reason to hold a read, gathered in one place
    logic rd_block;
    assign rd_block = dep_hit || io_block || lock_block
                      || ser_ff; // see RULE19
    assign rd_go_o = rd_req_i && rd_prior_done_i && instr_fetched_i
                     && !rd_block; // see RULE6 see RULE8
    // Prefetch is deliberately not compared with buffered writes
    assign fetch_go_o = fetch_req_i && prev_fetch_done_i && !ser_ff; // see RULE5 see RULE10

    // Inhibit held for the whole read cycle; cleared on the forced retry
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            inh_ff <= 1'b0;
        end else if (rd_go_o) begin
            inh_ff <= !retry_ff && (rd_spec_i || !wb_empty); // see RULE14 see RULE11
        end
    end
    // Combinational in the grant cycle so the bus sees it at once; held after
    assign io_inhibit_o = rd_go_o ? (!retry_ff && (rd_spec_i || !wb_empty)) : inh_ff;
    assign rd_discard_o = rd_done_i && io_decode_i && inh_ff; // see RULE16

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            retry_ff <= 1'b0;
        end else if (rd_discard_o) begin
            retry_ff <= 1'b1; // see RULE16
        end else if (rd_done_i) begin
            // Cleared when the repeated cycle ends, not at its grant
            retry_ff <= 1'b0;
        end
    end

    // Serialize: hold fetch and reads until the buffer drains
    logic ser_start;
    assign ser_start = ser_instr_i || psr_word_load_i || exc_taken_i || rd_discard_o; // see RULE20
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ser_ff <= 1'b0;
        // Set wins over the drain-done clear in the same cycle
        end else if (ser_start) begin
            ser_ff <= 1'b1; // see RULE19
        end else if (wb_empty || fatal_err_i) begin
            ser_ff <= 1'b0;
        end
    end
    assign serializing_o = ser_ff;
    // Refetch under the new privilege, or down the other stream
    assign flush_o = psr_word_load_i || br_mispredict_o; // see RULE21

    // Write buffer valid bits; fatal error drops everything unwritten
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            vld_ff <= '0;
        end else if (fatal_err_i) begin
            vld_ff <= '0; // see RULE22
        end else begin
            if (push) begin
                vld_ff[tail_ff] <= 1'b1;
            end
            if (pop) begin
                vld_ff[head_ff] <= 1'b0;
            end
        end
    end

    // Oldest entry pointer moves when the bus finishes it; fatal error sets it back to zero
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            head_ff <= '0;
        end else if (fatal_err_i) begin
            head_ff <= '0;
        end else if (pop) begin
            head_ff <= (head_ff == PW'(WB_DEPTH - 1)) ? '0 : head_ff + 1'b1;
        end
    end

    // Next free slot advances on each accepted result
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            tail_ff <= '0;
        end else if (fatal_err_i) begin
            tail_ff <= '0;
        end else if (push) begin
            tail_ff <= (tail_ff == PW'(WB_DEPTH - 1)) ? '0 : tail_ff + 1'b1;
        end
    end

    // Occupancy; push and pop together leave it as it is
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cnt_ff <= '0;
        end else if (fatal_err_i) begin
            cnt_ff <= '0;
        end else if (push && !pop) begin
            cnt_ff <= cnt_ff + 1'b1;
        end else if (pop && !push) begin
            cnt_ff <= cnt_ff - 1'b1;
        end
    end

    // Payload needs no reset; the valid bits guard it
    always_ff @(posedge clk_i) begin
        if (push) begin
            ref_ff[tail_ff] <= wr_ref_i;
            dat_ff[tail_ff] <= wr_data_i;
        end
    end

    // Restartable string ending: drop trace-pending, push the same pc
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            trace_clr_o <= 1'b0;
            saved_pc_valid_o <= 1'b0;
        end else begin
            trace_clr_o <= str_abort_i; // see RULE2
            saved_pc_valid_o <= str_abort_i;
        end
    end

    // Pc of the interrupted instruction, so a return resumes it
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            saved_pc_o <= '0;
        end else if (str_abort_i) begin
            saved_pc_o <= str_pc_i; // see RULE1 see RULE2
        end
    end

    // Static prediction at the loader
    logic pred;
    logic [31:0] tgt;
    logic [31:0] seq;
    // Target is the branch pc plus its signed displacement
    assign tgt = br_i.pc + br_i.disp;
    // Fixed step for the fall-through stream
    assign seq = br_i.pc + `PMO_INSTR_STEP;
    always_comb begin
        case (br_i.kind)
            PMO_BR_LE: pred = 1'b1; // see RULE12
            PMO_BR_NE: pred = 1'b1;
            PMO_BR_OTHER: begin
                // Negative displacement is a backward branch
                pred = br_i.disp[31];
            end
            default: pred = 1'b0;
        endcase
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            br_pred_taken_o <= 1'b0;
        end else if (br_valid_i) begin
            br_pred_taken_o <= pred; // see RULE13
        end
    end

    // Alternate stream kept for the redirect on a wrong guess
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            br_next_o <= '0;
            br_alt_o <= '0;
        end else if (br_valid_i) begin
            br_next_o <= pred ? tgt : seq;
            br_alt_o <= pred ? seq : tgt;
        end
    end
    // Compared with the registered guess, so resolve follows the load
    assign br_mispredict_o = br_resolve_i && (br_taken_i != br_pred_taken_o); // see RULE13
endmodule
`default_nettype wire

//--- rtl/pmo_regs.svh
// Constants for the pipeline memory-ordering controller
`ifndef PMO_REGS_SVH
`define PMO_REGS_SVH
`define PMO_IO_BASE 32'hFF000000
`define PMO_WB_DEPTH 2
`define PMO_AW 32
`define PMO_LW 3
`define PMO_WB_MAX 8
`define PMO_INSTR_STEP 32'h00000004
`endif

//--- rtl/pmo_pkg.sv
// Types for the pipeline memory-ordering controller
package pmo_pkg;
    typedef struct packed {
        logic [31:0] addr;
        logic [2:0] len;
    } pmo_ref_s;
    typedef enum logic [1:0] {
        PMO_BR_NONE,
        PMO_BR_LE,
        PMO_BR_NE,
        PMO_BR_OTHER
    } pmo_br_e;
    typedef struct packed {
        logic [31:0] pc;
        logic [31:0] disp;
        pmo_br_e kind;
    } pmo_branch_s;
endpackage

//--- dv/pmo_core_asserts.sv
// Concurrent checks on the memory-ordering controller ports
`timescale 1ns/1ns
`default_nettype none
`include "pmo_regs.svh"
module pmo_core_asserts (
    input wire logic clk_i, // Clock
    input wire logic sys_rst_i, // Reset
    input wire logic fetch_req_i, // Fetch wanted
    input wire logic prev_fetch_done_i, // Earlier fetched
    input wire logic fetch_go_o, // Fetch grant
    input wire logic serializing_o, // Draining
    input wire logic rd_go_o, // Read grant
    input wire logic rd_spec_i, // Speculative read
    input wire logic io_inhibit_o, // Inhibit
    input wire pmo_pkg::pmo_ref_s rd_ref_i, // Read ref
    input wire logic bus_wr_valid_o, // Write pending
    input wire logic [31:0] bus_wr_addr_o, // Oldest write
    input wire logic [2:0] bus_wr_len_o, // Oldest length
    input wire logic bus_wr_done_i, // Write done
    input wire logic rd_done_i, // Read done
    input wire logic io_decode_i, // Sensitive port
    input wire logic rd_discard_o, // Drop data
    input wire logic fatal_err_i, // Fatal error
    input wire logic br_resolve_i, // Resolve
    input wire logic br_taken_i, // Decision
    input wire logic br_pred_taken_o, // Prediction
    input wire logic br_mispredict_o // Redirect
);
    import pmo_pkg::*;
    logic ovl;
    // Wrap at the top of memory is ignored
    assign ovl = rd_ref_i.addr < bus_wr_addr_o + 32'(bus_wr_len_o)
        && bus_wr_addr_o < rd_ref_i.addr + 32'(rd_ref_i.len);
    logic retry_ff;
    // A forced repeat after a discard runs without inhibit
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            retry_ff <= 1'b0;
        end else if (rd_discard_o) begin
            retry_ff <= 1'b1;
        end else if (rd_done_i) begin
            retry_ff <= 1'b0;
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    a_fetch_gate: assert property (fetch_go_o ==
        (fetch_req_i && prev_fetch_done_i && !serializing_o)) else $error("fetch grant wrong");
    a_ser_no_read: assert property (serializing_o |-> !rd_go_o)
        else $error("read during drain");
    a_ser_drained: assert property ($fell(serializing_o) |-> !bus_wr_valid_o)
        else $error("drain ended early");
    a_hold_overlap: assert property (rd_go_o && bus_wr_valid_o |-> !ovl)
        else $error("overlapping read granted");
    a_region_wait: assert property (rd_go_o && bus_wr_valid_o
        && bus_wr_addr_o >= `PMO_IO_BASE |-> rd_ref_i.addr < `PMO_IO_BASE)
        else $error("region read passed write");
    a_inhibit_need: assert property (rd_go_o && !retry_ff
        && (rd_spec_i || bus_wr_valid_o) |-> io_inhibit_o) else $error("inhibit missing");
    a_retry_clean: assert property (rd_go_o && retry_ff |-> !io_inhibit_o)
        else $error("inhibit on repeated read");
    a_discard_why: assert property (rd_discard_o |-> rd_done_i && io_decode_i)
        else $error("discard without decode");
    a_discard_ser: assert property (rd_discard_o |=> serializing_o)
        else $error("no drain after discard");
    a_wr_hold: assert property (bus_wr_valid_o && !bus_wr_done_i && !fatal_err_i
        |=> bus_wr_valid_o && $stable(bus_wr_addr_o)) else $error("write moved");
    a_fatal_drop: assert property (fatal_err_i |=> !bus_wr_valid_o)
        else $error("pending write kept");
    a_mispredict: assert property (br_mispredict_o == (br_resolve_i
        && (br_taken_i != br_pred_taken_o))) else $error("redirect wrong");
    c_discard: cover property (rd_discard_o);
    c_fatal: cover property (fatal_err_i && bus_wr_valid_o);
    c_redirect: cover property (br_mispredict_o);
endmodule
bind pmo_core pmo_core_asserts chk_u (.*);
`default_nettype wire

//--- dv/pmo_bus_model.sv
// Bus partner: ends writes and reads, flags order-sensitive ports
`timescale 1ns/1ns
`default_nettype none
module pmo_bus_model (
    input wire logic clk_i, // Clock
    input wire logic sys_rst_i, // Reset
    input wire logic stall_i, // Hold writes
    input wire logic rd_go_i, // Read start
    input wire logic [31:0] rd_addr_i, // Read address
    input wire logic io_inhibit_i, // Inhibit
    input wire logic wr_valid_i, // Write pending
    output logic rd_done_o, // Read end pulse
    output logic io_decode_o, // Sensitive port
    output logic wr_done_o, // Write end pulse
    output logic [7:0] fx_o // Reads with side effects
);
    logic busy_ff;
    logic sens_ff;
    assign io_decode_o = rd_done_o & sens_ff;
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            busy_ff <= 1'b0;
            sens_ff <= 1'b0;
            rd_done_o <= 1'b0;
            wr_done_o <= 1'b0;
            fx_o <= 8'h00;
        end else begin
            wr_done_o <= wr_valid_i & ~wr_done_o & ~stall_i;
            rd_done_o <= busy_ff & ~rd_done_o;
            if (rd_go_i & ~busy_ff & ~rd_done_o) begin
                busy_ff <= 1'b1;
                sens_ff <= rd_addr_i[31:28] == 4'hA;
            end else if (rd_done_o) begin
                busy_ff <= 1'b0;
            end
            // Deselected while inhibited, so only clean reads disturb it
            if (rd_done_o & sens_ff & ~io_inhibit_i) begin
                fx_o <= fx_o + 8'h01;
            end
        end
    end
endmodule
`default_nettype wire

//--- dv/pmo_core_tb.sv
// Self-checking bench for the memory-ordering controller
`timescale 1ns/1ns
`default_nettype none
module pmo_core_tb;
    import pmo_pkg::*;
    logic clk_i = 0, sys_rst_i = 1, fetch_req_i = 0, prev_fetch_done_i = 0, br_valid_i = 0;
    logic br_resolve_i = 0, br_taken_i = 0, rd_req_i = 0, rd_spec_i = 0, rd_done_i, io_decode_i;
    logic rd_prior_done_i = 1, instr_fetched_i = 1, rd_interlocked_i = 0, wr_req_i = 0;
    logic instr_reads_done_i = 1, bus_wr_done_i, ser_instr_i = 0, psr_word_load_i = 0;
    logic exc_taken_i = 0, fatal_err_i = 0, str_abort_i = 0, stall = 0;
    logic [31:0] wr_data_i = 0, str_pc_i = 0, seed = 32'h0000E322;
    pmo_branch_s br_i = '0;
    pmo_ref_s rd_ref_i = '0, wr_ref_i = '0;
    logic fetch_go_o, br_pred_taken_o, br_mispredict_o, rd_go_o, io_inhibit_o, rd_discard_o;
    logic wr_ready_o, bus_wr_valid_o, flush_o, serializing_o, trace_clr_o, saved_pc_valid_o;
    logic [31:0] br_next_o, br_alt_o, bus_wr_addr_o, bus_wr_data_o, saved_pc_o;
    logic [2:0] bus_wr_len_o;
    logic [7:0] fx;
    logic [31:0] q[$];
    int errors = 0, tests_run = 0;
    pmo_core dut_u (.*);
    pmo_bus_model bm_u (.clk_i, .sys_rst_i, .stall_i(stall), .rd_go_i(rd_go_o),
        .rd_addr_i(rd_ref_i.addr), .io_inhibit_i(io_inhibit_o), .wr_valid_i(bus_wr_valid_o),
        .rd_done_o(rd_done_i), .io_decode_o(io_decode_i), .wr_done_o(bus_wr_done_i), .fx_o(fx));
    always #25 clk_i = ~clk_i;
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic pred(input pmo_branch_s b);
        return b.kind == PMO_BR_LE || b.kind == PMO_BR_NE
            || (b.kind == PMO_BR_OTHER && b.disp[31]);
    endfunction
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        tests_run++;
        if (s !== e) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic complete_run();
        $display("errors=%0d tests_run=%0d", errors, tests_run);
        if (errors == 0 && tests_run > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic tick(input int n = 1);
        repeat (n) @(posedge clk_i);
        #5;
    endtask
    // Leaves the request up so back-to-back calls never toggle it
    task automatic wr(input logic [31:0] a);
        wr_ref_i = '{a, 3'h4};
        wr_data_i = xs();
        wr_req_i = 1;
        repeat (40) begin
            @(posedge clk_i);
            if (wr_ready_o === 1'b1) break;
        end
        q.push_back(a);
        #5;
    endtask
    task automatic rd(input logic [31:0] a, input logic sp, output logic i1, i2, d);
        int g;
        rd_ref_i = '{a, 3'h4};
        rd_spec_i = sp;
        rd_req_i = 1;
        d = 0;
        g = 0;
        repeat (60) begin
            @(posedge clk_i);
            if (rd_go_o === 1'b1) begin
                if (g++ == 0) i1 = io_inhibit_o;
                i2 = io_inhibit_o;
            end
            if (rd_done_i === 1'b1) begin
                if (rd_discard_o === 1'b1) d = 1;
                else break;
            end
        end
        #5;
    endtask
    always @(posedge clk_i) if (bus_wr_done_i === 1'b1 && q.size() > 0) chk("wr order", q.pop_front(), bus_wr_addr_o);
    initial begin
        logic i1, i2, d, p;
        logic [31:0] r;
        tick(10);
        sys_rst_i = 0;
        for (int n = 0; n < 30; n++) begin
            r = xs();
            br_i = '{xs(), (n < 6) ? {n[0], 31'h10} : xs(), pmo_br_e'(n < 4 ? n : 32'(r[9:8]))};
            fetch_req_i = r[0];
            prev_fetch_done_i = r[1];
            br_taken_i = r[2];
            br_valid_i = 1;
            #1 chk("fetch go", 32'(r[0] & r[1]), 32'(fetch_go_o));
            tick();
            br_valid_i = 0;
            p = pred(br_i);
            chk("pred", 32'(p), 32'(br_pred_taken_o));
            chk("next", p ? br_i.pc + br_i.disp : br_i.pc + 32'h4, br_next_o);
            chk("alt", p ? br_i.pc + 32'h4 : br_i.pc + br_i.disp, br_alt_o);
            br_resolve_i = 1;
            #1 chk("redirect", 32'(br_taken_i ^ p), 32'(br_mispredict_o));
            tick();
            br_resolve_i = 0;
        end
        stall = 1;
        wr(32'h1000);
        wr(32'hFF000010);
        tick(3);
        chk("full stall", 0, 32'(wr_ready_o));
        wr_req_i = 0;
        for (int n = 0; n < 2; n++) begin
            rd_ref_i = '{n == 0 ? 32'h1002 : 32'hFF000100, 3'h4};
            rd_req_i = 1;
            tick(2);
            chk("rd held", 0, 32'(rd_go_o));
        end
        rd(32'h00F00000, 0, i1, i2, d);
        rd_req_i = 0;
        chk("bypass inh", 1, 32'(i1));
        stall = 0;
        tick(8);
        chk("drained", 0, 32'(bus_wr_valid_o));
        for (int n = 0; n < 3; n++) begin
            rd(n == 2 ? 32'hA0000040 : 32'h3000, n != 1, i1, i2, d);
            rd_req_i = 0;
            chk("inh first", 32'(n != 1), 32'(i1));
            chk("inh last", 32'(n == 0), 32'(i2));
            chk("discard", 32'(n == 2), 32'(d));
            tick();
        end
        chk("side effects", 1, 32'(fx));
        for (int n = 0; n < 2; n++) begin
            stall = 1;
            wr(xs() & 32'h0FFFFFFC);
            wr_req_i = 0;
            instr_reads_done_i = 0;
            rd_ref_i = '{32'h70000000, 3'h4};
            rd_interlocked_i = 1;
            rd_req_i = 1;
            ser_instr_i = (n == 0);
            exc_taken_i = (n == 1);
            fetch_req_i = 1;
            prev_fetch_done_i = 1;
            #1 chk("wr refused", 0, 32'(wr_ready_o));
            chk("lock held", 0, 32'(rd_go_o));
            tick();
            ser_instr_i = 0;
            exc_taken_i = 0;
            rd_req_i = 0;
            rd_interlocked_i = 0;
            instr_reads_done_i = 1;
            chk("serializing", 1, 32'(serializing_o));
            chk("fetch held", 0, 32'(fetch_go_o));
            stall = 0;
            tick(6);
            chk("ser done", 0, 32'(serializing_o));
        end
        for (int n = 0; n < 2; n++) begin
            stall = 1;
            wr(32'h4000);
            wr(32'h5000);
            wr_req_i = 0;
            fatal_err_i = (n == 0);
            sys_rst_i = (n == 1);
            tick();
            fatal_err_i = 0;
            sys_rst_i = 0;
            q.delete();
            chk("pending dropped", 0, 32'(bus_wr_valid_o));
        end
        stall = 0;
        str_pc_i = xs();
        str_abort_i = 1;
        tick();
        str_abort_i = 0;
        chk("trace clr", 1, 32'(trace_clr_o));
        chk("saved pc", str_pc_i, saved_pc_o);
        chk("pc valid", 1, 32'(saved_pc_valid_o));
        psr_word_load_i = 1;
        #1 chk("psr flush", 1, 32'(flush_o));
        tick();
        psr_word_load_i = 0;
        complete_run();
    end
    // Full run needs under 200 cycles; allow many times that
    initial begin
        #2000000;
        errors++;
        complete_run();
    end
endmodule
`default_nettype wire
